//--- logic/wdc_pkg.sv
package wdc_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] WDC_CTRL_OFS = 4'h0;
   localparam logic [3:0] WDC_STAT_OFS = 4'h4;
   localparam logic [3:0] WDC_TOP_OFS = 4'h8;
   localparam int WDC_KEY_LSB = 16;
   localparam int WDC_ON_BIT = 15;
   localparam int WDC_RUN_LSB = 8;
   localparam int WDC_SLP_LSB = 1;
   localparam int WDC_WIN_BIT = 0;
   localparam logic [15:0] WDC_CLEAR_KEY = 16'h5743;
   localparam logic [31:0] WDC_TOP_RST = 32'h0000_0400;
   localparam logic [4:0] WDC_FIELD_RST = 5'h00;

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [3:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic stb;
      logic cyc;
   } wdc_wb_req_t;

   typedef enum logic [1:0] {
      WDC_ST_OFF = 2'b00,
      WDC_ST_RUN = 2'b01,
      WDC_ST_FIRED = 2'b10
   } wdc_state_t;
endpackage

//--- logic/wdc_watchdog_control.sv
// Overview of operation
// - only 16-bit key write 0x5743 restarts count
// - key field bits 31-16, write-only, reads zero
// - enable bit 15 runs or stops watchdog
// - force-enable fuse overrides software enable bit
// - bits 12-8 show run postscale fuse
// - bits 5-1 show sleep postscale fuse
// - bit 0 selects windowed mode, resets zero
// - bits 14-13 read zero, ignore writes
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module wdc_watchdog_control
   import wdc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   input wire logic force_enable_fuse,
   input wire logic [4:0] run_postscale_fuse,
   input wire logic [4:0] sleep_postscale_fuse,
   output logic wdt_running,
   output logic window_active,
   output logic timeout_reset
);
   // ****************************************
   // fuse synchronisers and power-on capture
   // ****************************************
   logic [10:0] fuse_pin;
   wire [10:0] fuse_sync;
   logic [1:0] fill_q;
   logic load_done_q;
   logic [4:0] run_postscale_view_q;
   logic [4:0] sleep_postscale_view_q;

   assign fuse_pin = {force_enable_fuse, run_postscale_fuse,
                      sleep_postscale_fuse};

   // one two-stage synchroniser per fuse line
   for (genvar i = 0; i < 11; i++) begin : g_sync
      logic s1_q;
      logic s2_q;
      always_ff @(posedge mclk or posedge sys_rst) begin
         if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
         end else begin
            s1_q <= fuse_pin[i];
            s2_q <= s1_q;
         end
      end
      assign fuse_sync[i] = s2_q;
   end

   wire fuse_force = fuse_sync[10];

   // ****************************************
   // power-on capture of postscaler views
   // ****************************************
   // fill marks the synchroniser holding pin values
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fill_q <= 2'b00;
      end else begin
         fill_q <= {fill_q[0], 1'b1};
      end
   end

   // third edge after release: second stage is valid
   wire capture = fill_q[1] && !load_done_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         load_done_q <= 1'b0;
      end else if (capture) begin
         load_done_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         run_postscale_view_q <= WDC_FIELD_RST;
         sleep_postscale_view_q <= WDC_FIELD_RST;
      end else if (capture) begin
         run_postscale_view_q <= fuse_sync[9:5];
         sleep_postscale_view_q <= fuse_sync[4:0];
      end
   end

   // ****************************************
   // wishbone decode
   // ****************************************
   // address match used by decode and read mux
   function automatic logic wdc_hit(input logic [3:0] adr,
                                    input logic [3:0] ofs);
      return adr == ofs;
   endfunction

   // byte lane enable of a write
   function automatic logic wdc_lane(input logic [3:0] sel,
                                     input int idx);
      return sel[idx];
   endfunction

   wdc_wb_req_t req;
   assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i,
                  we: wb_we_i, stb: wb_stb_i, cyc: wb_cyc_i};

   logic ack_q;
   logic err_q;
   wire access = req.cyc && req.stb && !ack_q && !err_q;
   wire hit_ctrl = wdc_hit(req.adr, WDC_CTRL_OFS);
   wire hit_stat = wdc_hit(req.adr, WDC_STAT_OFS);
   wire hit_top = wdc_hit(req.adr, WDC_TOP_OFS);
   wire mapped = hit_ctrl || hit_stat || hit_top;
   wire wr_ctrl = access && req.we && hit_ctrl;
   wire wr_top = access && req.we && hit_top;
   wire wr_stat = access && req.we && hit_stat;

   // exactly the upper half-word lanes with the key
   wire key_hit = wr_ctrl && req.sel == 4'hC &&
                  req.dat[31:16] == WDC_CLEAR_KEY;
   wire lo_hi_lane = wr_ctrl && wdc_lane(req.sel, 1);
   wire lo_lo_lane = wr_ctrl && wdc_lane(req.sel, 0);
   wire flag_clear = wr_stat && wdc_lane(req.sel, 0) && req.dat[0];

   // ****************************************
   // control register
   // ****************************************
   logic sw_on_q;
   logic window_mode_enable_q;
   logic [31:0] timeout_top_q;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sw_on_q <= 1'b0;
      end else if (lo_hi_lane) begin
         sw_on_q <= req.dat[WDC_ON_BIT];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         window_mode_enable_q <= 1'b0;
      end else if (lo_lo_lane) begin
         window_mode_enable_q <= req.dat[WDC_WIN_BIT];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_top_q <= WDC_TOP_RST;
      end else if (wr_top) begin
         timeout_top_q <= req.dat;
      end
   end

   wire wdt_enable = fuse_force | sw_on_q;

   // ****************************************
   // counter and timeout
   // ****************************************
   wdc_state_t state_q;
   wdc_state_t state_d;
   logic [31:0] count_q;
   logic timeout_flag_q;
   wire expired = count_q >= timeout_top_q;
   wire half_top = count_q < {1'b0, timeout_top_q[31:1]};
   // clearing early in window mode is a fault
   wire early_clear = key_hit && window_mode_enable_q && half_top;

   always_comb begin
      state_d = state_q;
      case (state_q)
         WDC_ST_OFF: begin
            if (wdt_enable && load_done_q) begin
               state_d = WDC_ST_RUN;
            end
         end
         WDC_ST_RUN: begin
            if (!wdt_enable) begin
               state_d = WDC_ST_OFF;
            end else if (early_clear || (expired && !key_hit)) begin
               state_d = WDC_ST_FIRED;
            end
         end
         WDC_ST_FIRED: begin
            state_d = WDC_ST_FIRED;
         end
         default: begin
            state_d = WDC_ST_OFF;
         end
      endcase
   end

   // ****************************************
   // state and count registers
   // ****************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= WDC_ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= '0;
      end else if (state_q != WDC_ST_RUN || key_hit) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 32'h0000_0001;
      end
   end

   // sticky flag: set wins over software clear
   wire fire = state_q == WDC_ST_RUN && state_d == WDC_ST_FIRED;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_flag_q <= 1'b0;
      end else if (fire) begin
         timeout_flag_q <= 1'b1;
      end else if (flag_clear) begin
         timeout_flag_q <= 1'b0;
      end
   end

   // ****************************************
   // read data and outputs
   // ****************************************
   wire [31:0] ctrl_view = {16'h0000, sw_on_q, 2'b00,
                            run_postscale_view_q, 2'b00,
                            sleep_postscale_view_q,
                            window_mode_enable_q};
   wire [31:0] stat_view = {29'h0000_0000, wdt_enable,
                            state_q == WDC_ST_RUN, timeout_flag_q};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_view :
                        hit_stat ? stat_view :
                        hit_top ? timeout_top_q : 32'h0000_0000;

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= access && mapped;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         err_q <= 1'b0;
      end else begin
         err_q <= access && !mapped;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_dat_o <= '0;
      end else begin
         wb_dat_o <= (access && !req.we) ? rd_mux : 32'h0000_0000;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_running <= 1'b0;
      end else begin
         wdt_running <= state_d == WDC_ST_RUN;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         window_active <= 1'b0;
      end else begin
         window_active <= window_mode_enable_q;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         timeout_reset <= 1'b0;
      end else begin
         timeout_reset <= state_d == WDC_ST_FIRED;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;
endmodule
`default_nettype wire

//--- test/wdc_watchdog_control_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wdc_monitor
   import wdc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [3:0] wb_adr_i,
   input wire logic wb_we_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic force_enable_fuse,
   input wire logic [4:0] run_postscale_fuse,
   input wire logic [4:0] sleep_postscale_fuse,
   input wire logic wdt_running,
   input wire logic window_active,
   input wire logic timeout_reset
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire logic rdc = wb_ack_o && !wb_we_i && wb_adr_i == WDC_CTRL_OFS;
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   a_ack_latency: assert property (req |=> wb_ack_o || wb_err_o)
      else $error("no answer one cycle after request");
   a_ctrl_zero: assert property (rdc |-> wb_dat_o[31:16] == 16'h0000 &&
      wb_dat_o[14:13] == 2'b00) else $error("control zero bits not zero");
   a_view_fields: assert property (rdc |-> wb_dat_o[12:8] ==
      run_postscale_fuse) else $error("run view wrong");
   a_sleep_view: assert property (rdc |-> wb_dat_o[5:1] ==
      sleep_postscale_fuse) else $error("sleep view wrong");
   a_win_follows: assert property (rdc |-> wb_dat_o[0] == window_active)
      else $error("window output differs from bit");
   a_sw_off: assert property (!force_enable_fuse [*4] ##0 rdc &&
      !wb_dat_o[15] |-> !wdt_running) else $error("runs while disabled");
   a_fuse_forces: assert property (force_enable_fuse [*6] ##0
      !timeout_reset |-> wdt_running or ##1 timeout_reset)
      else $error("fuse does not force running");
   a_tmo_sticky: assert property (timeout_reset |=> timeout_reset)
      else $error("timeout dropped");
   a_tmo_cause: assert property ($rose(timeout_reset) |-> $past(wdt_running))
      else $error("timeout without running");
   c_timeout: cover property ($rose(timeout_reset));
   c_error: cover property (wb_err_o);
   c_running: cover property ($rose(wdt_running));
endmodule
bind wdc_watchdog_control wdc_monitor u_mon (.*);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import wdc_pkg::*;
;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic fen = 1'b0;
   logic [4:0] rpf = 5'h00;
   logic [4:0] spf = 5'h00;
   wdc_wb_req_t rq = '0;
   logic [31:0] dato;
   logic ack, err, run, win, tmo;
   logic [64:0] q[$];
   logic [64:0] e;
   int err_count = 0;
   int num_checks = 0;
   localparam logic [64:0] WR = 65'h0;
   localparam logic [3:0] CT = WDC_CTRL_OFS;
   wdc_watchdog_control uut (.mclk(mclk), .sys_rst(sys_rst),
      .wb_adr_i(rq.adr), .wb_dat_i(rq.dat), .wb_sel_i(rq.sel),
      .wb_we_i(rq.we), .wb_stb_i(rq.stb), .wb_cyc_i(rq.cyc),
      .wb_dat_o(dato), .wb_ack_o(ack), .wb_err_o(err),
      .force_enable_fuse(fen), .run_postscale_fuse(rpf),
      .sleep_postscale_fuse(spf), .wdt_running(run),
      .window_active(win), .timeout_reset(tmo));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   function logic [64:0] rd(logic [31:0] v);
      return {1'b0, 32'hFFFF_FFFF, v};
   endfunction
   function logic [31:0] cv(logic on, logic wn);
      return {16'h0000, on, 2'b00, rpf, 2'b00, spf, wn};
   endfunction
   task fail(input string m);
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask
   task chk(input logic a, input logic b);
      num_checks++;
      if (a !== b) fail("output level");
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task bus(input logic [3:0] a, s, input logic w, input logic [31:0] d,
      input logic [64:0] x);
      int n;
      q.push_back(x);
      rq <= '{a, d, s, w, 1'b1, 1'b1};
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (ack !== 1'b1 && err !== 1'b1) begin
         fail("bus timeout");
         print_verdict;
      end
      rq <= '0;
      @(posedge mclk);
   endtask
   task start(input logic [31:0] c);
      sys_rst <= 1'b1;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge mclk);
      bus(WDC_TOP_OFS, 4'hF, 1'b1, 32'h0000_0040, WR);
      bus(CT, 4'h3, 1'b1, c, WR);
   endtask
   always @(posedge mclk) begin
      if (ack === 1'b1 || err === 1'b1) begin
         e = q.pop_front();
         num_checks++;
         if ({err, dato & e[63:32]} !== {e[64], e[31:0]}) fail("bus result");
      end
   end
   initial begin
      void'($urandom(56));
      rpf <= 5'($urandom);
      spf <= 5'($urandom);
      @(posedge mclk);
      start(32'h0);
      bus(CT, 4'hF, 1'b0, 0, rd(cv(0, 0)));
      bus(4'hC, 4'hF, 1'b0, 0, 65'h1_0000_0000_0000_0000);
      bus(WDC_STAT_OFS, 4'hF, 1'b0, 0, {1'b0, 32'h7, 32'h0});
      bus(CT, 4'hF, 1'b1, '1, WR);
      bus(CT, 4'hF, 1'b0, 0, rd(cv(1, 1)));
      chk(win, 1'b1);
      chk(run, 1'b1);
      start(32'h0000_8000);
      repeat (4) begin
         repeat (40) @(posedge mclk);
         bus(CT, 4'hC, 1'b1, 32'h5743_0000, WR);
      end
      chk(tmo, 1'b0);
      bus(CT, 4'hC, 1'b1, 32'h5744_0000, WR);
      bus(CT, 4'h4, 1'b1, 32'h0043_0000, WR);
      bus(CT, 4'h8, 1'b1, 32'h5700_0000, WR);
      repeat (70) @(posedge mclk);
      chk(tmo, 1'b1);
      bus(WDC_STAT_OFS, 4'hF, 1'b0, 0, {1'b0, 32'h1, 32'h1});
      start(32'h0000_8001);
      chk(win, 1'b1);
      bus(CT, 4'hC, 1'b1, 32'h5743_0000, WR);
      repeat (2) @(posedge mclk);
      chk(tmo, 1'b1);
      start(32'h0000_8000);
      bus(CT, 4'h3, 1'b1, 32'h0, WR);
      repeat (3) @(posedge mclk);
      chk(run, 1'b0);
      repeat (100) @(posedge mclk);
      chk(tmo, 1'b0);
      fen <= 1'b1;
      repeat (8) @(posedge mclk);
      chk(run, 1'b1);
      bus(CT, 4'hF, 1'b0, 0, rd(cv(0, 0)));
      chk(run, 1'b1);
      print_verdict;
   end
endmodule
`default_nettype wire
